/* rtl/usb_gia_pkg.sv */
package usb_gia_pkg;
   localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hbe;
   localparam logic [7:0] FUNC_ADDR_ADDR = 8'hc6;
   localparam logic [7:0] EP_INDEX_ADDR = 8'hc7;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h10;
   localparam logic [7:0] FUNC_ADDR_RESET = 8'h80;
   localparam logic [7:0] EP_INDEX_RESET = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_MASK = 8'h39;
   localparam logic [7:0] EP_INDEX_MASK = 8'h0f;
   localparam int WAKE_BIT = 5;
   localparam int EOR_BIT = 4;
   localparam int SOF_BIT = 3;
   localparam int SUSPEND_BIT = 0;
   localparam int FILTER_BIT = 7;
   localparam int SUSPEND_TIME_MS = 3;
   localparam int CLK_KHZ = 40000;
   localparam int SUSPEND_CYCLES = SUSPEND_TIME_MS * CLK_KHZ;
endpackage

/* rtl/usb_global_irq_addr_ep_index.sv */
`timescale 1ns/1ps
// Functional notes
// - Wake enable bit 5 gates wake flag onto the USB interrupt.
// - End-of-reset enable bit 4 gates its flag; register resets to 10h.
// - Frame-start enable bit 3 gates the frame-start flag.
// - Suspend enable bit 0 gates the suspend flag.
// - Enable bits 7-6, 2, 1 read zero; firmware writes no ones.
// - Address bit 7 enables address filtering; register resets to 80h.
// - Address field bits 6-0 zero after reset and on USB bus reset.
// - Suspend flag sets after bus idle three frame periods.
// - Wake flag sets on non-idle bus while suspended.
// - Address-valid clear means respond to address zero.
// - Endpoint index field selects endpoint for indexed registers.
module usb_global_irq_addr_ep_index #(
   parameter int SUSPEND_CYCLES = usb_gia_pkg::SUSPEND_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic bus_idle_i,
   input wire logic bus_reset_i,
   input wire logic end_of_reset_i,
   input wire logic frame_start_i,
   input wire logic address_valid_bit_i,
   input wire logic [3:0] flag_clear_i,
   output logic usb_irq_o,
   output logic wake_flag_o,
   output logic suspend_flag_o,
   output logic address_filter_enable_o,
   output logic [6:0] match_address_o,
   output logic [3:0] endpoint_index_field_o
);
   logic [7:0] usb_global_irq_enable;
   logic [7:0] usb_function_address;
   logic [7:0] usb_endpoint_index;
   logic [1:0] idle_sync;
   logic [1:0] rst_sync;
   logic idle_s;
   logic rst_s;
   logic idle_expired;
   logic eor_flag;
   logic sof_flag;
   logic next_irq;

   if (SUSPEND_CYCLES < 2) begin : g_limit_check
      $error("SUSPEND_CYCLES too small");
   end

   // Bus pins come from the transceiver domain
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         idle_sync <= 2'b00;
         rst_sync <= 2'b00;
      end else begin
         // Only the second stage feeds logic
         idle_sync <= {idle_sync[0], bus_idle_i};
         rst_sync <= {rst_sync[0], bus_reset_i};
      end
   end
   assign idle_s = idle_sync[1];
   assign rst_s = rst_sync[1];

   usb_idle_timer #(
      .LIMIT(SUSPEND_CYCLES)
   ) u_idle (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .idle_i(idle_s),
      .expired_o(idle_expired)
   );

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         usb_global_irq_enable <= usb_gia_pkg::IRQ_ENABLE_RESET;
      end else if (sfr_wr_i && sfr_addr_i == usb_gia_pkg::IRQ_ENABLE_ADDR) begin
         usb_global_irq_enable <= sfr_wdata_i & usb_gia_pkg::IRQ_ENABLE_MASK;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         usb_function_address <= usb_gia_pkg::FUNC_ADDR_RESET;
      end else if (rst_s) begin
         usb_function_address[6:0] <= 7'h00;
      end else if (sfr_wr_i && sfr_addr_i == usb_gia_pkg::FUNC_ADDR_ADDR) begin
         usb_function_address <= sfr_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         usb_endpoint_index <= usb_gia_pkg::EP_INDEX_RESET;
      end else if (sfr_wr_i && sfr_addr_i == usb_gia_pkg::EP_INDEX_ADDR) begin
         usb_endpoint_index <= sfr_wdata_i & usb_gia_pkg::EP_INDEX_MASK;
      end
   end

   // Event flags: set wins over a simultaneous clear
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         wake_flag_o <= 1'b0;
         suspend_flag_o <= 1'b0;
         eor_flag <= 1'b0;
         sof_flag <= 1'b0;
      end else begin
         if (suspend_flag_o && !idle_s) begin
            wake_flag_o <= 1'b1;
         end else if (flag_clear_i[3]) begin
            wake_flag_o <= 1'b0;
         end
         if (idle_expired) begin
            suspend_flag_o <= 1'b1;
         end else if (flag_clear_i[0]) begin
            suspend_flag_o <= 1'b0;
         end
         if (end_of_reset_i) begin
            eor_flag <= 1'b1;
         end else if (flag_clear_i[2]) begin
            eor_flag <= 1'b0;
         end
         if (frame_start_i) begin
            sof_flag <= 1'b1;
         end else if (flag_clear_i[1]) begin
            sof_flag <= 1'b0;
         end
      end
   end

   always_comb begin
      next_irq = (wake_flag_o && usb_global_irq_enable[usb_gia_pkg::WAKE_BIT])
         || (eor_flag && usb_global_irq_enable[usb_gia_pkg::EOR_BIT])
         || (sof_flag && usb_global_irq_enable[usb_gia_pkg::SOF_BIT])
         || (suspend_flag_o && usb_global_irq_enable[usb_gia_pkg::SUSPEND_BIT]);
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         usb_irq_o <= 1'b0;
         address_filter_enable_o <= 1'b1;
         match_address_o <= 7'h00;
         endpoint_index_field_o <= 4'h0;
      end else begin
         usb_irq_o <= next_irq;
         address_filter_enable_o <= usb_function_address[usb_gia_pkg::FILTER_BIT];
         // Default address until firmware marks the new one valid
         match_address_o <= address_valid_bit_i ? usb_function_address[6:0] : 7'h00;
         endpoint_index_field_o <= usb_endpoint_index[3:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         case (sfr_addr_i)
            usb_gia_pkg::IRQ_ENABLE_ADDR: begin
               sfr_rdata_o <= usb_global_irq_enable;
            end
            usb_gia_pkg::FUNC_ADDR_ADDR: begin
               sfr_rdata_o <= usb_function_address;
            end
            usb_gia_pkg::EP_INDEX_ADDR: begin
               sfr_rdata_o <= usb_endpoint_index;
            end
            default: begin
               sfr_rdata_o <= 8'h00;
            end
         endcase
      end
   end

   sequence s_idle_done;
      idle_expired;
   endsequence

   a_irq_enable_reserved: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (usb_global_irq_enable & ~usb_gia_pkg::IRQ_ENABLE_MASK) == 8'h00)
      else $error("reserved enable bit set");
   a_suspend_sets: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_idle_done |=> suspend_flag_o)
      else $error("suspend flag not set");
   a_wake_sets: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (suspend_flag_o && !idle_s) |=> wake_flag_o)
      else $error("wake flag not set");
   a_bus_reset_addr: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      rst_s |=> usb_function_address[6:0] == 7'h00)
      else $error("address not cleared");
   a_irq_wake: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (wake_flag_o && usb_global_irq_enable[5]) |=> usb_irq_o)
      else $error("wake irq missing");
   a_irq_eor: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (eor_flag && usb_global_irq_enable[4]) |=> usb_irq_o)
      else $error("eor irq missing");
   a_irq_sof: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (sof_flag && usb_global_irq_enable[3]) |=> usb_irq_o)
      else $error("sof irq missing");
   a_irq_suspend: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (suspend_flag_o && usb_global_irq_enable[0]) |=> usb_irq_o)
      else $error("suspend irq missing");
   a_irq_masked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (usb_global_irq_enable == 8'h00) |=> !usb_irq_o)
      else $error("irq without enable");
   a_default_addr: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !address_valid_bit_i |=> match_address_o == 7'h00)
      else $error("nonzero address while invalid");
   a_filter_follows: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      1'b1 |=> address_filter_enable_o == $past(usb_function_address[7]))
      else $error("filter enable mismatch");
   a_ep_index: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (sfr_wr_i && sfr_addr_i == usb_gia_pkg::EP_INDEX_ADDR)
      |=> ##1 endpoint_index_field_o == $past(sfr_wdata_i[3:0], 2))
      else $error("endpoint index mismatch");
endmodule

/* rtl/usb_idle_timer.sv */
`timescale 1ns/1ps
// Counts idle cycles; pulses once when the limit is reached
module usb_idle_timer #(
   parameter int LIMIT = 120000
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic idle_i,
   output logic expired_o
);
   logic [31:0] count;

   if (LIMIT < 2) begin : g_limit_check
      $error("LIMIT too small");
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !idle_i) begin
         count <= 32'h0000_0000;
         expired_o <= 1'b0;
      end else if (count == 32'(LIMIT - 1)) begin
         count <= count + 32'h0000_0001;
         expired_o <= 1'b1;
      end else begin
         expired_o <= 1'b0;
         if (count < 32'(LIMIT)) begin
            count <= count + 32'h0000_0001;
         end
      end
   end
endmodule

/* tb/usb_global_irq_addr_ep_index_tb.sv */
`timescale 1ns/1ps
module usb_global_irq_addr_ep_index_tb;
   // Short idle limit keeps the suspend test brief
   localparam int SC = 16;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, rdata, r;
   logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, valid = 1'b0, rd_d1 = 1'b0, rd_d2 = 1'b0;
   logic [1:0] ev = 2'h0, mode = 2'h1;
   logic [3:0] clr = 4'h0, epi;
   logic irq, wake, susp, filt, bus_idle, bus_reset;
   logic [6:0] match;
   logic [7:0] q[$];
   int fail_count = 0, n_checks = 0, cyc = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   usb_global_irq_addr_ep_index #(.SUSPEND_CYCLES(SC)) usb_global_irq_addr_ep_index_i (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
      .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(rdata),
      .bus_idle_i(bus_idle), .bus_reset_i(bus_reset), .end_of_reset_i(ev[1]),
      .frame_start_i(ev[0]), .address_valid_bit_i(valid), .flag_clear_i(clr),
      .usb_irq_o(irq), .wake_flag_o(wake), .suspend_flag_o(susp),
      .address_filter_enable_o(filt), .match_address_o(match), .endpoint_index_field_o(epi));
   usb_host_model usb_host_model_i (.ref_clk_i(ref_clk_i), .mode_i(mode),
      .bus_idle_o(bus_idle), .bus_reset_o(bus_reset));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t value got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i) #1;
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      tick(1);
      sfr_wr_i = 1'b0;
   endtask
   // Expected data is queued; the monitor compares once rdata has settled
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      q.push_back(exp);
      @(posedge ref_clk_i) #1;
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      tick(1);
      sfr_rd_i = 1'b0;
      tick(2);
   endtask
   task automatic strobe(input logic [1:0] e, input logic [3:0] c);
      @(posedge ref_clk_i) #1;
      ev = e;
      clr = c;
      tick(1);
      ev = 2'h0;
      clr = 4'h0;
   endtask
   task automatic print_verdict;
      $display("Counts: %0d checks, %0d mismatches", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      rd_d1 <= sfr_rd_i;
      rd_d2 <= rd_d1;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         print_verdict();
      end
   end
   always @(negedge ref_clk_i) if (rd_d2) chk8(rdata, q.pop_front());
   initial begin
      void'($urandom(66375));
      tick(6);
      srst_i = 1'b0;
      rd(usb_gia_pkg::IRQ_ENABLE_ADDR, 8'h10);
      rd(usb_gia_pkg::FUNC_ADDR_ADDR, 8'h80);
      rd(usb_gia_pkg::EP_INDEX_ADDR, 8'h00);
      rd(8'hbd, 8'h00);
      wr(usb_gia_pkg::IRQ_ENABLE_ADDR, 8'hff);
      rd(usb_gia_pkg::IRQ_ENABLE_ADDR, 8'h39);
      for (int i = 0; i < 4; i++) begin
         r = 8'($urandom);
         wr(usb_gia_pkg::EP_INDEX_ADDR, r);
         rd(usb_gia_pkg::EP_INDEX_ADDR, {4'h0, r[3:0]});
         chk8({4'h0, epi}, {4'h0, r[3:0]});
      end
      $display("Test registers done");
      // Masked case turns every other enable on to catch crossed bits
      for (int i = 0; i < 2; i++) begin
         for (int en = 0; en < 2; en++) begin
            wr(usb_gia_pkg::IRQ_ENABLE_ADDR, en ? (8'h10 >> i) : (~(8'h10 >> i) & 8'h39));
            strobe(2'h2 >> i, 4'h0);
            tick(2);
            chk1(irq, en[0]);
            strobe(2'h0, 4'h4 >> i);
            tick(2);
            chk1(irq, 1'b0);
         end
      end
      $display("Test events done");
      wr(usb_gia_pkg::IRQ_ENABLE_ADDR, 8'h00);
      mode = 2'h0;
      tick(12);
      chk1(susp, 1'b0);
      for (int n = 0; n < 40 && susp !== 1'b1; n++) tick(1);
      chk1(susp, 1'b1);
      chk1(irq, 1'b0);
      wr(usb_gia_pkg::IRQ_ENABLE_ADDR, 8'h01);
      tick(3);
      chk1(irq, 1'b1);
      wr(usb_gia_pkg::IRQ_ENABLE_ADDR, 8'h20);
      mode = 2'h1;
      tick(8);
      chk1(wake, 1'b1);
      chk1(irq, 1'b1);
      wr(usb_gia_pkg::IRQ_ENABLE_ADDR, 8'h00);
      tick(3);
      chk1(irq, 1'b0);
      // Suspend first: a still-set suspend flag re-arms wake over its clear
      strobe(2'h0, 4'h1);
      strobe(2'h0, 4'h8);
      tick(1);
      chk1(wake, 1'b0);
      chk1(susp, 1'b0);
      $display("Test suspend done");
      valid = 1'b1;
      for (int i = 0; i < 3; i++) begin
         r = 8'($urandom);
         wr(usb_gia_pkg::FUNC_ADDR_ADDR, {1'b1, r[6:0]});
         tick(2);
         chk8({1'b0, match}, {1'b0, r[6:0]});
         chk1(filt, 1'b1);
      end
      valid = 1'b0;
      tick(2);
      chk8({1'b0, match}, 8'h00);
      wr(usb_gia_pkg::FUNC_ADDR_ADDR, 8'h05);
      tick(2);
      chk1(filt, 1'b0);
      wr(usb_gia_pkg::FUNC_ADDR_ADDR, 8'h85);
      mode = 2'h2;
      tick(6);
      mode = 2'h1;
      rd(usb_gia_pkg::FUNC_ADDR_ADDR, 8'h80);
      $display("Test address done");
      print_verdict();
   end
endmodule

/* tb/usb_host_model.sv */
`timescale 1ns/1ps
// Far side of the bus: 0 idle J state, 1 traffic, 2 bus reset
module usb_host_model (
   input wire logic ref_clk_i,
   input wire logic [1:0] mode_i,
   output logic bus_idle_o,
   output logic bus_reset_o
);
   always_ff @(posedge ref_clk_i) begin
      bus_idle_o <= (mode_i == 2'h0);
      bus_reset_o <= (mode_i == 2'h2);
   end
endmodule
